// *** rtl/wsh_top.sv ***
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "wsh_regs.svh"
// Behaviour
// - Start still high at weld-done rise: weld-done held until start falls.
// - Start already low: weld-done cleared after configured period, default one cycle.
// - Simulated software start uses the same weld-done period handling.
// - Weld-done offset +/-50 from hold end when early; a late one comes hold length plus offset after hold end; not before hold start plus one.
// - Option chooses weld-done after good welds only or after defective too.
// - Weld-done per spot in single and repeat, at seam end in seam.
// - Dress request set at count threshold only while another dressing is allowed.
// - Electrode outputs show the electrode of the selected program; status per electrode.
// - Stop-at-life option blocks welding, reports dressing needed, awaits caps dressed.
// - Caps dressed clears that electrode's dress request.
// - Cap-change warning set at configurable count threshold.
// - End-of-life rising or caps changed clears the cap-change warning.
// - End of life with stop option blocks until caps changed clears it.
// - Caps changed clears the electrode's end-of-life status.
// - Start rising edge launches selected program only when ready; start one also needs no prelift.
// - Start one runs 1-5, start two 6-10; interlocked, prelift locks start one.
// - Temperature input checked at start and during run; low reports overtemperature.
// - Valve set at program start, then optional first squeeze, then squeeze.
// - Dropping start before squeeze ends cancels the schedule.
// - Squeeze timing waits while pressure contact is high.
// - Start held past squeeze latches all three weld intervals in single/repeat.
// - Seam mode with start released finishes current weld cycle then stops.
// - A latched sequence is cancelled only by opening the stop circuit.
// - Hold interval, weld-done at its end or at the offset from it, then valve released.
// - Dressing program 5 or 10 completes that gun's dress request.
// - Current only when external, internal and program weld enables are all on.
module wsh_top
   import wsh_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rst,
   // AHB-Lite slave.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Discrete I/O.
   input  wire wsh_pins_t   pins,
   input  wire logic        weld_defect,
   output wsh_outs_t        outs
);
   ////////////////////////////////////////////////////////////////////////////
   wsh_pins_t  pq, pd;
   wsh_state_t st_reg, st_next;
   wsh_elec_t  el [2];
   logic [31:0] ctrl_reg, time_reg, wdcf_reg, thr_reg;
   logic [7:0]  wa_reg;
   logic        wr_reg, s1d_reg, gun_reg, pend_reg, defect_reg, wdhs_reg;
   logic [3:0]  prog_reg;
   logic [1:0]  widx_reg;
   logic [8:0]  cnt_reg;
   logic [7:0]  wdc_reg;
   wire         s1, gun_sel_blk, ot_clr;

   // Pins pass two flops; a delayed copy gives edges.
   wsh_sync #(.W(16)) u_sync (.clk(clk), .rst(rst), .d(pins), .q(pq));

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pd      <= '0;
         s1d_reg <= 1'b0;
      end
      else
      begin
         pd      <= pq;
         s1d_reg <= s1;
      end
   end

   // Program number of a gun from its selection lines.
   function automatic logic [3:0] prog_of(input logic gun, input logic [2:0] sel);
      logic [3:0] base;
      base = gun ? 4'h6 : 4'h1;
      prog_of = sel[2] ? (gun ? 4'ha : 4'h5) : base + {2'b00, sel[1:0]};
   endfunction : prog_of

   ////////////////////////////////////////////////////////////////////////////
   // Configuration fields.
   wire        sim     = ctrl_reg[`WSH_B_SIM_START];
   assign      s1      = pq.start1 | sim;
   wire [1:0]  mode    = ctrl_reg[`WSH_B_MODE+:2];
   wire        seam    = (mode == WSH_SEAM);
   wire        rept    = (mode == WSH_REPEAT);
   wire        stop_lf = ctrl_reg[`WSH_B_STOP_LIFE];
   wire [7:0]  fsqz_l  = ctrl_reg[`WSH_B_FSQZ_EN] ? time_reg[7:0] : 8'h00;
   wire [7:0]  sqz_l   = time_reg[15:8];
   wire [7:0]  weld_l  = time_reg[23:16];
   wire [7:0]  hold_l  = time_reg[31:24];
   wire [7:0]  wdp_l   = wdcf_reg[7:0];
   wire [5:0]  off_l   = wdcf_reg[31:26];
   wire [9:0]  pwo     = wdcf_reg[25:16];

   // Weld-done moment from hold start (from hold end once in post-hold), offset clamped to +/-50, moment to one.
   wire signed [7:0] ofs_raw = wdcf_reg[15:8];
   wire signed [7:0] ofs = (ofs_raw > `WSH_WD_OFS_LIM) ? `WSH_WD_OFS_LIM :
                           (ofs_raw < -`WSH_WD_OFS_LIM) ? -`WSH_WD_OFS_LIM : ofs_raw;
   wire signed [9:0] at_s  = $signed({2'b00, hold_l}) + {{2{ofs[7]}}, ofs};
   wire        [8:0] wd_at = (at_s < 10'sd1) ? 9'h001 : at_s[8:0];

   ////////////////////////////////////////////////////////////////////////////
   // Start acceptance, interlocks and selected electrode.
   wire        tick   = pq.mains & ~pd.mains;
   wire        r1     = s1 & ~s1d_reg;
   wire        r2     = pq.start2 & ~pd.start2;
   wire        blk_g  = stop_lf & (gun_sel_blk);
   wire        idle   = (st_reg == WSH_IDLE);
   wire        ready  = idle & pq.stop_ok & ~blk_g;
   wire        acc1   = r1 & ~pq.start2 & ~pq.prelift;
   wire        acc2   = r2 & ~s1;
   wire        accept = ready & (acc1 | acc2);
   wire        agun   = acc2 & ~acc1;
   wire        start  = gun_reg ? pq.start2 : s1;
   wire        s_fall = gun_reg ? (~pq.start2 & pd.start2) : (~s1 & s1d_reg);
   wire        cnt_ok = (st_reg != WSH_SQZ) | ~pq.press;
   wire        run_ok = st_reg != WSH_IDLE;
   wire        dprog  = (prog_reg == 4'h5) | (prog_reg == 4'ha);

   // Selected electrode status, dress-needed and block condition.
   wsh_elec_t  es;
   assign es          = el[gun_reg];
   wire        dneed  = stop_lf & (es.wear >= thr_reg[15:8]);
   assign gun_sel_blk = dneed | es.eol;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer interval ends and weld-done firing.
   wire        fire   = pend_reg & ((st_reg == WSH_HOLD) | (st_reg == WSH_POST)) &
                        (cnt_reg >= wd_at);
   wire        fs_end = cnt_reg >= {1'b0, fsqz_l};
   wire        sq_end = cnt_reg >= {1'b0, sqz_l};
   wire        wl_end = cnt_reg >= {1'b0, weld_l};
   wire        hl_end = cnt_reg >= {1'b0, hold_l};
   wire        of_end = cnt_reg >= {3'b000, off_l};
   wire        wd_ok  = ~weld_defect | ctrl_reg[`WSH_B_WD_DEFECT];
   wire        fin    = ((st_reg == WSH_HOLD) & hl_end & (~pend_reg | fire)) |
                        ((st_reg == WSH_POST) & fire);
   wire        dressed_p = (pq.dressed & ~pd.dressed) | (fin & dprog);
   wire        changed_p = pq.changed & ~pd.changed;

   // Next state.
   always_comb
   begin
      st_next = st_reg;
      case (st_reg)
         WSH_IDLE:
            if (accept)
               st_next = (fsqz_l != 8'h00) ? WSH_FSQZ : WSH_SQZ;
         WSH_FSQZ:
            if (~start)
               st_next = WSH_IDLE;
            else if (fs_end)
               st_next = WSH_SQZ;
         WSH_SQZ:
            if (~start)
               st_next = WSH_IDLE;
            else if (sq_end)
               st_next = WSH_WELD;
         WSH_WELD:
            if (wl_end)
            begin
               if (seam)
                  st_next = start ? WSH_WELD : WSH_HOLD;
               else if (widx_reg == 2'h2)
                  st_next = WSH_HOLD;
            end
         WSH_HOLD:
            if (hl_end)
               st_next = fin ? ((rept & start) ? WSH_OFFT : WSH_IDLE) : WSH_POST;
         WSH_POST:
            if (fire)
               st_next = (rept & start) ? WSH_OFFT : WSH_IDLE;
         WSH_OFFT:
            if (of_end)
               st_next = WSH_SQZ;
         default:
            st_next = WSH_IDLE;
      endcase
      if (~pq.stop_ok)
         st_next = WSH_IDLE;
   end

   wire restart = (st_next != st_reg) | ((st_reg == WSH_WELD) & wl_end);

   // State, interval counter and weld index; counts only on mains ticks.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_reg   <= WSH_IDLE;
         cnt_reg  <= 9'h000;
         widx_reg <= 2'h0;
      end
      else
      begin
         st_reg   <= st_next;
         cnt_reg  <= restart ? 9'h000 :
                     (tick & cnt_ok & (cnt_reg != 9'h1ff)) ? cnt_reg + 9'h001 : cnt_reg;
         widx_reg <= (st_reg != WSH_WELD) ? 2'h0 :
                     (wl_end & ~seam) ? widx_reg + 2'h1 : widx_reg;
      end
   end

   // Program, gun and weld-done qualification captured along the run.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         gun_reg    <= 1'b0;
         prog_reg   <= 4'h1;
         pend_reg   <= 1'b0;
         defect_reg <= 1'b0;
      end
      else
      begin
         if (accept)
         begin
            gun_reg  <= agun;
            prog_reg <= agun ? prog_of(1'b1, pq.sel2) : prog_of(1'b0, pq.sel1);
         end
         defect_reg <= accept ? 1'b0 : defect_reg | (weld_defect & (st_reg == WSH_WELD));
         pend_reg   <= (st_next == WSH_HOLD && st_reg != WSH_HOLD) ?
                       (~defect_reg | ctrl_reg[`WSH_B_WD_DEFECT]) :
                       (pend_reg & ~fire & run_ok);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Weld-done pulse stretch: held for start, else for the period.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         outs.weld_done_signal <= 1'b0;
         wdhs_reg <= 1'b0;
         wdc_reg  <= 8'h00;
      end
      else if (fire)
      begin
         outs.weld_done_signal <= 1'b1;
         wdhs_reg <= start;
         wdc_reg  <= 8'h00;
      end
      else
      begin
         if (wdhs_reg & s_fall)
            outs.weld_done_signal <= 1'b0;
         if (~wdhs_reg & (wdc_reg >= wdp_l))
            outs.weld_done_signal <= 1'b0;
         if (tick & (wdc_reg != 8'hff))
            wdc_reg <= wdc_reg + 8'h01;
      end
   end

   // Per-electrode status keepers, one for each gun.
   generate
      for (genvar g = 0; g < 2; g++)
      begin : g_el
         wsh_elec u_el (
            .clk     (clk),
            .rst     (rst),
            .spot    (fin & ~dprog & (gun_reg == g[0])),
            .dressed (dressed_p & (gun_reg == g[0])),
            .changed (changed_p & (gun_reg == g[0])),
            .thr     (wsh_thr_t'(thr_reg)),
            .st      (el[g])
         );
      end
   endgenerate

   // Registered outputs; valve follows the next state so it rises with start.
   // Valve stays at least one clock past the weld-done rise, so the release always comes after it.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         outs.ready        <= 1'b0;
         outs.valve        <= 1'b0;
         outs.weld_cur     <= 1'b0;
         outs.dress_req    <= 1'b0;
         outs.cap_warn     <= 1'b0;
         outs.tip_eol      <= 1'b0;
         outs.dress_needed <= 1'b0;
         outs.overtemp     <= 1'b0;
      end
      else
      begin
         outs.ready    <= ready & ~accept;
         outs.valve    <= ((st_next != WSH_IDLE) & (st_next != WSH_OFFT)) | fire;
         outs.weld_cur <= (st_next == WSH_WELD) & pq.weld_ext &
                          ctrl_reg[`WSH_B_WELD_INT] & pwo[prog_reg - 4'h1];
         outs.dress_req    <= es.dress_req;
         outs.cap_warn     <= es.warn;
         outs.tip_eol      <= es.eol;
         outs.dress_needed <= dneed;
         outs.overtemp <= ((accept | run_ok) & ~pq.temp_ok) |
                          (outs.overtemp & ~ot_clr);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: zero wait states, always OKAY, unmapped reads as zero.
   wire ap     = hsel & htrans[1] & hready;
   wire wr_go  = wr_reg;
   assign ot_clr = wr_go & (wa_reg == `WSH_CTRL_OFS) & hwdata[`WSH_B_OT_CLR];
   wire [31:0] stat_w = {16'h0000, prog_reg, gun_reg, widx_reg, 2'b00, st_reg};
   wire [31:0] cnt_w  = {16'h0000, es.dcnt, es.wear};
   wire [7:0]  ra     = haddr[7:0];
   wire [31:0] rd_w   = (ra == `WSH_CTRL_OFS) ? ctrl_reg :
                        (ra == `WSH_TIME_OFS) ? time_reg :
                        (ra == `WSH_WDCF_OFS) ? wdcf_reg :
                        (ra == `WSH_THR_OFS)  ? thr_reg  :
                        (ra == `WSH_STAT_OFS) ? stat_w   :
                        (ra == `WSH_CNT_OFS)  ? cnt_w    : 32'h0000_0000;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_reg    <= 1'b0;
         wa_reg    <= 8'h00;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         wr_reg    <= ap & hwrite;
         if (ap)
         begin
            wa_reg <= ra;
            hrdata <= hwrite ? 32'h0000_0000 : rd_w;
         end
      end
   end

   // Register writes in the data phase.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_reg <= `WSH_CTRL_RST;
         time_reg <= `WSH_TIME_RST;
         wdcf_reg <= `WSH_WDCF_RST;
         thr_reg  <= `WSH_THR_RST;
      end
      else if (wr_go)
      begin
         if (wa_reg == `WSH_CTRL_OFS)
            ctrl_reg <= hwdata & 32'h0000_00bf;
         if (wa_reg == `WSH_TIME_OFS)
            time_reg <= hwdata;
         if (wa_reg == `WSH_WDCF_OFS)
            wdcf_reg <= hwdata;
         if (wa_reg == `WSH_THR_OFS)
            thr_reg <= hwdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   wd_hold_a: assert property (@(posedge clk) disable iff (rst)
      outs.weld_done_signal & wdhs_reg & ~s_fall & ~fire |=> outs.weld_done_signal)
      else $error("weld-done dropped while start held");
   wd_period_a: assert property (@(posedge clk) disable iff (rst)
      outs.weld_done_signal & ~wdhs_reg & (wdc_reg >= wdp_l) & ~fire
      |=> ~outs.weld_done_signal)
      else $error("weld-done not cleared after period");
   sim_start_a: assert property (@(posedge clk) disable iff (rst)
      sim & idle & ready & ~s1d_reg & ~pq.start2 & ~pq.prelift |=> ~idle)
      else $error("simulated start not accepted");
   wd_early_a: assert property (@(posedge clk) disable iff (rst)
      $rose(outs.weld_done_signal) |-> $past(cnt_reg) >= 9'h001)
      else $error("weld-done before one cycle of hold");
   lock_a: assert property (@(posedge clk) disable iff (rst)
      idle & pq.prelift & ~r2 |=> idle)
      else $error("start accepted under prelift");
   valve_a: assert property (@(posedge clk) disable iff (rst)
      accept |=> outs.valve & ~outs.ready)
      else $error("valve not set at start");
   abort_a: assert property (@(posedge clk) disable iff (rst)
      (st_reg == WSH_SQZ) & ~start |=> idle ##1 ~outs.valve)
      else $error("squeeze not cancelled");
   latch_a: assert property (@(posedge clk) disable iff (rst)
      (st_reg == WSH_WELD) & pq.stop_ok & ~wl_end |=> st_reg == WSH_WELD)
      else $error("latched weld left early");
   valve_off_a: assert property (@(posedge clk) disable iff (rst)
      fire & (st_next == WSH_IDLE)
      |=> outs.weld_done_signal & outs.valve ##1 ~outs.valve)
      else $error("valve not released after weld-done");
   current_a: assert property (@(posedge clk) disable iff (rst)
      outs.weld_cur |-> $past(pq.weld_ext) & $past(ctrl_reg[`WSH_B_WELD_INT]))
      else $error("current without enables");
   wd_c: cover property (@(posedge clk) disable iff (rst) $rose(outs.weld_done_signal));
   seam_c: cover property (@(posedge clk) disable iff (rst)
      seam & (st_reg == WSH_WELD) & wl_end & ~start);
   abort_c: cover property (@(posedge clk) disable iff (rst)
      (st_reg == WSH_SQZ) & ~start);
endmodule : wsh_top

// *** rtl/wsh_regs.svh ***
`ifndef WSH_REGS_SVH
`define WSH_REGS_SVH
// Register byte offsets.
`define WSH_CTRL_OFS  8'h00
`define WSH_TIME_OFS  8'h04
`define WSH_WDCF_OFS  8'h08
`define WSH_THR_OFS   8'h0c
`define WSH_STAT_OFS  8'h10
`define WSH_CNT_OFS   8'h14
// Reset values.
`define WSH_CTRL_RST  32'h0000_0001
`define WSH_TIME_RST  32'h0a05_0a00
`define WSH_WDCF_RST  32'h0bff_0001
`define WSH_THR_RST   32'h0a08_c864
// Control bit positions.
`define WSH_B_WELD_INT  0
`define WSH_B_WD_DEFECT 1
`define WSH_B_STOP_LIFE 2
`define WSH_B_MODE      3
`define WSH_B_SIM_START 5
`define WSH_B_OT_CLR    6
`define WSH_B_FSQZ_EN   7
// Weld-done offset limit in mains cycles.
`define WSH_WD_OFS_LIM  8'sd50
`endif

// *** rtl/wsh_pkg.sv ***
package wsh_pkg;
   typedef enum logic [6:0] {
      WSH_IDLE = 7'b0000001,
      WSH_FSQZ = 7'b0000010,
      WSH_SQZ  = 7'b0000100,
      WSH_WELD = 7'b0001000,
      WSH_HOLD = 7'b0010000,
      WSH_POST = 7'b0100000,
      WSH_OFFT = 7'b1000000
   } wsh_state_t;
   typedef enum logic [1:0] {
      WSH_SINGLE = 2'h0,
      WSH_REPEAT = 2'h1,
      WSH_SEAM   = 2'h2
   } wsh_mode_t;
   typedef struct packed {
      logic       start1;
      logic       start2;
      logic       prelift;
      logic       temp_ok;
      logic       press;
      logic       weld_ext;
      logic       stop_ok;
      logic       dressed;
      logic       changed;
      logic       mains;
      logic [2:0] sel1;
      logic [2:0] sel2;
   } wsh_pins_t;
   typedef struct packed {
      logic ready;
      logic valve;
      logic weld_cur;
      logic weld_done_signal;
      logic dress_req;
      logic cap_warn;
      logic tip_eol;
      logic dress_needed;
      logic overtemp;
   } wsh_outs_t;
   typedef struct packed {
      logic [7:0] dmax;
      logic [7:0] warn;
      logic [7:0] wear_max;
      logic [7:0] dress;
   } wsh_thr_t;
   typedef struct packed {
      logic       dress_req;
      logic       warn;
      logic       eol;
      logic [7:0] wear;
      logic [7:0] dcnt;
   } wsh_elec_t;
endpackage : wsh_pkg

// *** rtl/wsh_sync.sv ***
`timescale 1ns/1ps
module wsh_sync #(parameter int W = 16)
(
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         rst,
   // Asynchronous in, synchronous out.
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // Two flops; the first is read only by the second.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_reg <= '0;
         q        <= '0;
      end
      else
      begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule : wsh_sync

// *** rtl/wsh_elec.sv ***
`timescale 1ns/1ps
module wsh_elec
   import wsh_pkg::*;
(
   // Clock and reset.
   input  wire logic      clk,
   input  wire logic      rst,
   // Events, one-cycle pulses.
   input  wire logic      spot,
   input  wire logic      dressed,
   input  wire logic      changed,
   // Thresholds and status.
   input  wire wsh_thr_t  thr,
   output wsh_elec_t      st
);
   wire [7:0] wear_inc = (st.wear == 8'hff) ? st.wear : st.wear + 8'h01;
   wire [7:0] dcnt_inc = (st.dcnt == 8'hff) ? st.dcnt : st.dcnt + 8'h01;
   wire       dr_set   = spot & (wear_inc == thr.dress) & (st.dcnt < thr.dmax);
   wire       eol_set  = dressed & (dcnt_inc == thr.dmax);
   wire       warn_set = dressed & (dcnt_inc == thr.warn);

   // Counters and sticky statuses; a set in the clearing cycle wins.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         st <= '0;
      else
      begin
         st.wear <= (dressed | changed) ? 8'h00 : (spot ? wear_inc : st.wear);
         st.dcnt <= changed ? 8'h00 : (dressed ? dcnt_inc : st.dcnt);
         st.dress_req <= dr_set | (st.dress_req & ~dressed);
         st.eol <= eol_set | (st.eol & ~changed);
         st.warn <= warn_set | (st.warn & ~changed & ~eol_set);
      end
   end
endmodule : wsh_elec

// *** test/wsh_robot.sv ***
`timescale 1ns/1ps
module wsh_robot
   import wsh_pkg::*;
(
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       rst,
   // Commands from the bench.
   input  wire logic       go1,
   input  wire logic       go2,
   input  wire logic       wext,
   input  wire logic       pl,
   input  wire logic [2:0] sel,
   // Discrete lines toward the timer.
   output wsh_pins_t       pins
);
   logic [2:0] ph_reg;
   logic [2:0] sel_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Mains reference ticks once every eight clocks; a real supply never pauses.
   always_ff @(posedge clk or posedge rst)
      if (rst)
         ph_reg <= 3'h0;
      else
         ph_reg <= ph_reg + 3'h1;

   // Selection moves only while both starts are low, so it is settled before an edge.
   always_ff @(posedge clk or posedge rst)
      if (rst)
         sel_reg <= 3'h0;
      else if (!go1 && !go2)
         sel_reg <= sel;

   // Unused acknowledges stay low, temperature and stop circuit stay healthy.
   assign pins = '{start1: go1, start2: go2, prelift: pl, temp_ok: 1'b1, press: 1'b0,
                   weld_ext: wext, stop_ok: 1'b1, dressed: 1'b0, changed: 1'b0,
                   mains: ph_reg[2], sel1: sel_reg, sel2: sel_reg};
endmodule : wsh_robot

// *** test/tb_weld_sequence_handshake.sv ***
`timescale 1ns/1ps
`include "wsh_regs.svh"
module tb_weld_sequence_handshake
   import wsh_pkg::*;
;
   logic        clk = 0, rst = 1, hsel = 0, hwrite = 0, go1 = 0, go2 = 0;
   logic        wext = 1, pl = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2, sel = 3'h0;
   logic        hreadyout, hresp;
   wsh_pins_t   pins;
   wsh_outs_t   outs;
   wire [8:0]   o = outs;
   int          failures = 0, num_checks = 0, seed = 35358, n, p, c0, cur_cnt = 0;
   logic [7:0]  adr[5] = '{`WSH_CTRL_OFS, `WSH_TIME_OFS, `WSH_WDCF_OFS, `WSH_THR_OFS, 8'h18};
   logic [31:0] exv[5] = '{`WSH_CTRL_RST, `WSH_TIME_RST, `WSH_WDCF_RST, `WSH_THR_RST, 32'h0};

   ////////////////////////////////////////////////////////////////////////////
   // Free-running clock; current enable is watched on every rising edge for the run.
   always #10 clk = ~clk;
   always @(posedge clk) if (o[6] === 1'b1) cur_cnt <= cur_cnt + 1;

   wsh_robot i_robot (.clk(clk), .rst(rst), .go1(go1), .go2(go2), .wext(wext), .pl(pl),
                      .sel(sel), .pins(pins));
   wsh_top i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
                  .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
                  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
                  .weld_defect(1'b0), .outs(outs));

   ////////////////////////////////////////////////////////////////////////////
   task report_and_stop;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop

   task chk(input logic ok, input string m);
      num_checks++;
      if (ok !== 1'b1)
      begin
         failures++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : chk

   // Samples on falling edges so that registered outputs have settled.
   task wt(input int b, input logic v, input int lim, input bit must, output int k);
      k = 0;
      while (o[b] !== v && k < lim)
      begin
         @(negedge clk);
         k++;
      end
      if (must && k >= lim)
      begin
         failures++;
         $display("wrong value at %0t: wait ran out", $time);
         report_and_stop;
      end
   endtask : wt

   // One single word transfer; address and data phases each wait for ready.
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int k;
      k = 0;
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
      r = hrdata;
      if (k >= 50)
      begin
         failures++;
         $display("wrong value at %0t: bus hang", $time);
         report_and_stop;
      end
   endtask : bus

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++)
      begin
         bus(1'b0, adr[i], 32'h0, rd);
         chk(rd === exv[i], "reset value");
      end
      bus(1'b1, 8'h18, 32'hffff_ffff, rd);
      bus(1'b0, 8'h18, 32'h0, rd);
      chk(rd === 32'h0, "unmapped write");
      // Short intervals keep each sequence near ten mains ticks.
      bus(1'b1, `WSH_TIME_OFS, 32'h0301_0200, rd);
      bus(1'b0, `WSH_TIME_OFS, 32'h0, rd);
      chk(rd === 32'h0301_0200, "time readback");
      wt(8, 1'b1, 50, 1, n);
      $display("test registers done");
      // Start held past weld-done: the output waits for the falling start.
      @(posedge clk) go1 <= 1'b1;
      wt(7, 1'b1, 20, 1, n);
      chk(n <= 4 && o[8] === 1'b0, "valve late");
      wt(5, 1'b1, 300, 1, n);
      chk(o[7] === 1'b1, "valve gone before done");
      repeat (40) @(negedge clk);
      chk(o[5] === 1'b1, "done not held");
      @(posedge clk) go1 <= 1'b0;
      wt(5, 1'b0, 8, 1, n);
      wt(7, 1'b0, 8, 1, n);
      $display("test held start done");
      // Start dropped during squeeze cancels the schedule with no done.
      wt(8, 1'b1, 50, 1, n);
      @(posedge clk) go1 <= 1'b1;
      wt(7, 1'b1, 20, 1, n);
      @(posedge clk) go1 <= 1'b0;
      wt(7, 1'b0, 20, 1, n);
      wt(5, 1'b1, 150, 0, n);
      chk(n === 150, "done after abort");
      $display("test abort done");
      // Prelift locks the first start out.
      wt(8, 1'b1, 50, 1, n);
      @(posedge clk) pl <= 1'b1;
      repeat (4) @(posedge clk);
      go1 <= 1'b1;
      wt(7, 1'b1, 40, 0, n);
      chk(n === 40, "start under prelift");
      @(posedge clk) go1 <= 1'b0;
      pl <= 1'b0;
      $display("test prelift done");
      // A low dress threshold lets the runs below reach the dress request.
      bus(1'b1, `WSH_THR_OFS, 32'h0a08_c802, rd);
      // Random period, program and weld enable; start released once latched.
      for (int i = 0; i < 4; i++)
      begin
         p = 1 + ($random(seed) & 3);
         bus(1'b1, `WSH_WDCF_OFS, 32'h0bff_0000 | p, rd);
         wext <= 1'($random(seed));
         sel <= 3'($random(seed) & 3);
         wt(8, 1'b1, 50, 1, n);
         @(posedge clk) c0 = cur_cnt;
         go1 <= 1'b1;
         wt(7, 1'b1, 20, 1, n);
         repeat (36) @(posedge clk);
         go1 <= 1'b0;
         wt(5, 1'b1, 300, 1, n);
         wt(5, 1'b0, p * 8 + 8, 1, n);
         chk(n >= (p - 1) * 8 - 2, "done too short");
         chk((cur_cnt != c0) === wext, "current enable");
         chk(o[4:0] === 5'h10, "electrode status");
      end
      $display("test latched runs done");
      // Software start held high: done waits for the software start to drop.
      bus(1'b1, `WSH_CTRL_OFS, 32'h0000_0021, rd);
      wt(5, 1'b1, 300, 1, n);
      bus(1'b1, `WSH_CTRL_OFS, 32'h0000_0001, rd);
      wt(5, 1'b0, 8, 1, n);
      $display("test simulated start done");
      report_and_stop;
   end
endmodule : tb_weld_sequence_handshake
